// file: core/cie_alu.sv
// Data path for the AND and rotate-through-carry operations.
// Assumes operands come from the same clock domain; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module cie_alu (
    input  wire logic [7:0] w_i,
    input  wire logic [7:0] f_i,
    input  wire logic       carry_i,
    input  wire logic [1:0] sel_i,
    output logic      [7:0] res_o,
    output logic            carry_o,
    output logic            zero_o
);
    logic [7:0] and_res;
    logic [7:0] rl_res;
    logic [7:0] rr_res;

    assign and_res = w_i & f_i;
    // Carry into bit 0, bit 7 out
    assign rl_res  = {f_i[6:0], carry_i};
    // Carry into bit 7, bit 0 out
    assign rr_res  = {carry_i, f_i[7:1]};

    // Result select by operation code, AND by default
    assign res_o   = (sel_i == cie_pkg::ALU_RL) ? rl_res :
                     (sel_i == cie_pkg::ALU_RR) ? rr_res : and_res;
    assign carry_o = (sel_i == cie_pkg::ALU_RL) ? f_i[7] :
                     (sel_i == cie_pkg::ALU_RR) ? f_i[0] : carry_i;
    assign zero_o  = (and_res == 8'h00);
endmodule
`default_nettype wire

// file: core/cie_core.sv
// Execution core for AND, bit-test-skip-clear, rotates, return and sleep.
// Assumes one instruction per clock, presented already fetched and
// synchronous to core_clk_i; other opcodes execute as no-ops here.
`timescale 1ns/100ps
`default_nettype none
module cie_core (
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_i,
    input  wire logic [cie_pkg::INSTR_W-1:0] instr_i,
    input  wire logic                        instr_valid_i,
    input  wire logic                        wake_i,
    input  wire logic                        call_i,
    output logic      [cie_pkg::PC_W-1:0]    program_counter_o,
    output logic      [cie_pkg::DATA_W-1:0]  w_o,
    output cie_pkg::cie_status_s             status_o,
    output logic      [cie_pkg::WDT_W-1:0]   watchdog_counter_o,
    output logic                             sleeping_o,
    output logic                             osc_run_o,
    output logic                             discard_o
);
    cie_pkg::cie_state_e             state_q;
    cie_pkg::cie_state_e             state_d;
    logic [cie_pkg::DATA_W-1:0]      regs_q [cie_pkg::NREGS];
    logic [cie_pkg::DATA_W-1:0]      w_q;
    logic [cie_pkg::DATA_W-1:0]      w_d;
    logic [cie_pkg::PC_W-1:0]        pc_q;
    logic [cie_pkg::PC_W-1:0]        pc_d;
    logic [cie_pkg::PC_W-1:0]        stack_q [cie_pkg::STACK_D];
    logic [cie_pkg::SP_W-1:0]        sp_q;
    logic [cie_pkg::SP_W-1:0]        sp_d;
    logic [cie_pkg::WDT_W-1:0]       wdt_q;
    logic [cie_pkg::WDT_W-1:0]       wdt_d;
    logic [cie_pkg::PRE_W-1:0]       pre_q;
    logic [cie_pkg::PRE_W-1:0]       pre_d;
    cie_pkg::cie_status_s            st_q;
    cie_pkg::cie_status_s            st_d;
    cie_pkg::cie_fwr_s               fwr;
    logic                            sleeping_q;
    logic                            osc_q;
    logic                            discard_q;
    logic                            wake_meta_q;
    logic                            wake_sync_q;

    // Decoded fields
    wire [5:0]                  op6;
    wire [3:0]                  op4;
    wire                        dest;
    wire [2:0]                  bsel;
    wire [cie_pkg::ADDR_W-1:0]  faddr;
    wire [cie_pkg::DATA_W-1:0]  fval;
    wire                        go;
    wire                        is_and;
    wire                        is_rl;
    wire                        is_rr;
    wire                        is_btsc;
    wire                        is_ret;
    wire                        is_sleep;
    wire                        skip;
    wire [1:0]                  alu_sel;
    wire [cie_pkg::DATA_W-1:0]  alu_res;
    wire                        alu_c;
    wire                        alu_z;
    wire [cie_pkg::SP_W-1:0]    sp_dec;

    assign op6   = instr_i[cie_pkg::OP_HI:cie_pkg::OP6_LO];
    assign op4   = instr_i[cie_pkg::OP_HI:cie_pkg::OP4_LO];
    assign dest  = instr_i[cie_pkg::DEST_BIT];
    assign bsel  = instr_i[cie_pkg::BIT_HI:cie_pkg::BIT_LO];
    assign faddr = instr_i[cie_pkg::ADDR_W-1:0];
    assign fval  = regs_q[faddr];

    // Decode only in the execute state with a valid word
    assign go       = (state_q == cie_pkg::CIE_EXEC) && instr_valid_i;
    assign is_and   = go && (op6 == cie_pkg::OP_AND_WF);
    assign is_rl    = go && (op6 == cie_pkg::OP_RLC);
    assign is_rr    = go && (op6 == cie_pkg::OP_RRC);
    assign is_btsc  = go && (op4 == cie_pkg::OP_BTSC);
    assign is_ret   = go && (instr_i == cie_pkg::OP_RET);
    assign is_sleep = go && (instr_i == cie_pkg::OP_SLEEP);
    // Skip only when tested bit clear
    assign skip     = is_btsc && !fval[bsel];
    assign alu_sel  = is_rl ? cie_pkg::ALU_RL : (is_rr ? cie_pkg::ALU_RR : cie_pkg::ALU_AND);
    assign sp_dec   = sp_q - cie_pkg::SP_STEP;

    // Program counter advanced by one word
    function automatic logic [cie_pkg::PC_W-1:0] pc_inc(input logic [cie_pkg::PC_W-1:0] v);
        return v + cie_pkg::PC_STEP;
    endfunction

    cie_alu u_alu (
        .w_i     (w_q),
        .f_i     (fval),
        .carry_i (st_q.carry),
        .sel_i   (alu_sel),
        .res_o   (alu_res),
        .carry_o (alu_c),
        .zero_o  (alu_z)
    );

    assign fwr = '{we:   (is_and || is_rl || is_rr) && dest,
                   addr: faddr,
                   data: alu_res};

    // Next-state logic for sequencing, W, flags and watchdog
    always_comb begin
        state_d = state_q;
        w_d     = w_q;
        pc_d    = pc_q;
        sp_d    = sp_q;
        st_d    = st_q;
        wdt_d   = wdt_q;
        pre_d   = pre_q;
        // Free-running watchdog while awake, flush cycles included
        if (state_q != cie_pkg::CIE_SLEEP) begin
            pre_d = pre_q + cie_pkg::PRE_STEP;
            if (pre_q == '1) begin
                wdt_d = wdt_q + cie_pkg::WDT_STEP;
            end
        end
        case (state_q)
            cie_pkg::CIE_EXEC: begin
                if (instr_valid_i) begin
                    pc_d = pc_inc(pc_q);
                end
                if (call_i && go) begin
                    sp_d = sp_q + cie_pkg::SP_STEP;
                end
                if (is_and) begin
                    st_d.zero = alu_z;
                    if (!dest) begin
                        w_d = alu_res;
                    end
                end
                if (is_rl || is_rr) begin
                    st_d.carry = alu_c;
                    if (!dest) begin
                        w_d = alu_res;
                    end
                end
                if (skip) begin
                    state_d = cie_pkg::CIE_FLUSH;
                end
                if (is_ret) begin
                    pc_d    = stack_q[sp_dec];
                    sp_d    = sp_dec;
                    state_d = cie_pkg::CIE_FLUSH;
                end
                if (is_sleep) begin
                    wdt_d = cie_pkg::WDT_CLR;
                    pre_d = cie_pkg::PRE_CLR;
                    st_d.watchdog_expiry_flag = 1'b1;
                    st_d.sleep_entered_flag_n = 1'b0;
                    state_d = cie_pkg::CIE_SLEEP;
                end
            end
            cie_pkg::CIE_FLUSH: begin
                // Second cycle executes as a no-operation
                if (instr_valid_i) begin
                    pc_d = pc_inc(pc_q);
                end
                state_d = cie_pkg::CIE_EXEC;
            end
            cie_pkg::CIE_SLEEP: begin
                if (wake_sync_q) begin
                    state_d = cie_pkg::CIE_EXEC;
                end
            end
            default: begin
                state_d = cie_pkg::CIE_EXEC;
            end
        endcase
    end

    // Sequencer and core registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= cie_pkg::CIE_EXEC;
            w_q     <= cie_pkg::W_RST;
            pc_q    <= cie_pkg::PC_RST;
            sp_q    <= cie_pkg::SP_RST;
            wdt_q   <= cie_pkg::WDT_CLR;
            pre_q   <= cie_pkg::PRE_CLR;
            st_q    <= '{carry: 1'b0, zero: 1'b0,
                         watchdog_expiry_flag: 1'b1, sleep_entered_flag_n: 1'b1};
        end else begin
            state_q <= state_d;
            w_q     <= w_d;
            pc_q    <= pc_d;
            sp_q    <= sp_d;
            wdt_q   <= wdt_d;
            pre_q   <= pre_d;
            st_q    <= st_d;
        end
    end

    // File register array write port
    always_ff @(posedge core_clk_i) begin
        if (fwr.we) begin
            regs_q[fwr.addr] <= fwr.data;
        end
    end

    // Return address push on call
    always_ff @(posedge core_clk_i) begin
        if (call_i && go) begin
            stack_q[sp_q] <= pc_inc(pc_q);
        end
    end

    // Wake request arrives from outside, two flops
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wake_meta_q <= 1'b0;
            wake_sync_q <= 1'b0;
        end else begin
            wake_meta_q <= wake_i;
            wake_sync_q <= wake_meta_q;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sleeping_q <= 1'b0;
            osc_q      <= 1'b1;
            discard_q  <= 1'b0;
        end else begin
            sleeping_q <= (state_d == cie_pkg::CIE_SLEEP);
            osc_q      <= (state_d != cie_pkg::CIE_SLEEP);
            discard_q  <= (state_d == cie_pkg::CIE_FLUSH);
        end
    end

    assign program_counter_o  = pc_q;
    assign w_o                = w_q;
    assign status_o           = st_q;
    assign watchdog_counter_o = wdt_q;
    assign sleeping_o         = sleeping_q;
    assign osc_run_o          = osc_q;
    assign discard_o          = discard_q;
endmodule
`default_nettype wire

// file: core/cie_pkg.sv
// Constants, types and encodings for the instruction execution subset core.
// Assumes a 14-bit instruction word fetched one instruction cycle ahead.
// Behaviour
// - AND W with file, only zero flag
// - AND destination: 0 to W, 1 to file
// - Bit test clear: bit set executes next
// - Bit clear discards next, two cycles
// - Rotate left through carry, carry only
// - Rotate right through carry, carry only
// - Rotate destination: 0 to W, 1 to file
// - Sleep clears watchdog counter and prescaler
// - Sleep sets expiry flag, clears sleep flag
// - Sleep then enters sleep, oscillator stops
// - Return pops stack into counter, two cycles
package cie_pkg;

    localparam int unsigned DATA_W    = 8;
    localparam int unsigned ADDR_W    = 7;
    localparam int unsigned INSTR_W   = 14;
    localparam int unsigned PC_W      = 13;
    localparam int unsigned STACK_D   = 8;
    localparam int unsigned SP_W      = 3;
    localparam int unsigned WDT_W     = 8;
    localparam int unsigned PRE_W     = 8;
    localparam int unsigned NREGS     = 128;

    // Opcode field positions
    localparam int unsigned OP_HI     = 13;
    localparam int unsigned OP6_LO    = 8;
    localparam int unsigned OP4_LO    = 10;
    localparam int unsigned DEST_BIT  = 7;
    localparam int unsigned BIT_HI    = 9;
    localparam int unsigned BIT_LO    = 7;

    // Opcodes, six-bit byte group
    localparam logic [5:0] OP_AND_WF  = 6'h05;
    localparam logic [5:0] OP_RLC     = 6'h0D;
    localparam logic [5:0] OP_RRC     = 6'h0C;
    // Opcode, four-bit bit group
    localparam logic [3:0] OP_BTSC    = 4'h6;
    // Whole-word encodings
    localparam logic [13:0] OP_RET    = 14'h0008;
    localparam logic [13:0] OP_SLEEP  = 14'h0063;
    localparam logic [13:0] OP_NOP    = 14'h0000;

    // Reset values, increment steps and zero byte
    localparam logic [DATA_W-1:0] W_RST     = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST    = 13'h0000;
    localparam logic [WDT_W-1:0]  WDT_CLR   = 8'h00;
    localparam logic [PRE_W-1:0]  PRE_CLR   = 8'h00;
    localparam logic [SP_W-1:0]   SP_RST    = 3'h0;
    localparam logic [PC_W-1:0]   PC_STEP   = 13'h0001;
    localparam logic [SP_W-1:0]   SP_STEP   = 3'h1;
    localparam logic [DATA_W-1:0] ZERO_B    = 8'h00;
    localparam logic [PRE_W-1:0]  PRE_STEP  = 8'h01;
    localparam logic [WDT_W-1:0]  WDT_STEP  = 8'h01;

    // Data path operation select
    localparam logic [1:0]        ALU_AND   = 2'h0;
    localparam logic [1:0]        ALU_RL    = 2'h1;
    localparam logic [1:0]        ALU_RR    = 2'h2;

    typedef enum logic [2:0] {
        CIE_EXEC,
        CIE_FLUSH,
        CIE_SLEEP
    } cie_state_e;

    // Status flags carried together
    typedef struct packed {
        logic carry;
        logic zero;
        logic watchdog_expiry_flag;
        logic sleep_entered_flag_n;
    } cie_status_s;

    // File register write request
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cie_fwr_s;

endpackage

// file: verification/cie_core_monitor.sv
// Concurrent checks on the execution core ports.
// Assumes it is bound to cie_core and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cie_core_monitor (
    input wire logic                        core_clk_i,
    input wire logic                        rst_i,
    input wire logic [cie_pkg::INSTR_W-1:0] instr_i,
    input wire logic                        instr_valid_i,
    input wire logic                        wake_i,
    input wire logic                        call_i,
    input wire logic [cie_pkg::PC_W-1:0]    program_counter_o,
    input wire logic [cie_pkg::DATA_W-1:0]  w_o,
    input wire cie_pkg::cie_status_s        status_o,
    input wire logic [cie_pkg::WDT_W-1:0]   watchdog_counter_o,
    input wire logic                        sleeping_o,
    input wire logic                        osc_run_o,
    input wire logic                        discard_o
);
    // Decode of a word that is really taken
    wire logic       live   = instr_valid_i && !discard_o && !sleeping_o;
    wire logic [5:0] op6    = instr_i[13:8];
    wire logic       dst    = instr_i[7];
    wire logic       is_and = live && op6 == cie_pkg::OP_AND_WF;
    wire logic       is_rl  = live && op6 == cie_pkg::OP_RLC;
    wire logic       is_rr  = live && op6 == cie_pkg::OP_RRC;
    wire logic       is_bt  = live && instr_i[13:10] == cie_pkg::OP_BTSC;
    wire logic       is_ret = live && instr_i == cie_pkg::OP_RET;
    wire logic       is_slp = live && instr_i == cie_pkg::OP_SLEEP;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_and_flags_only: assert property (is_and |=>
        status_o[3] == $past(status_o[3]) && status_o[1:0] == $past(status_o[1:0]))
        else $error("and changed a flag other than zero");
    a_and_to_file: assert property (is_and && dst |=> $stable(w_o))
        else $error("and to file changed w");
    a_rot_carry_only: assert property ((is_rl || is_rr) |=> $stable(status_o[2:0]))
        else $error("rotate changed a flag other than carry");
    a_rot_to_file: assert property ((is_rl || is_rr) && dst |=> $stable(w_o))
        else $error("rotate to file changed w");
    a_rl_carry_in: assert property (is_rl && !dst |=> w_o[0] == $past(status_o.carry))
        else $error("left rotate bit 0 not old carry");
    a_rr_carry_in: assert property (is_rr && !dst |=> w_o[7] == $past(status_o.carry))
        else $error("right rotate bit 7 not old carry");
    a_btsc_no_flags: assert property (is_bt |=> $stable(status_o) && $stable(w_o))
        else $error("bit test changed state");
    a_ret_two_cyc: assert property (is_ret |=> discard_o && $stable(status_o) ##1 !discard_o)
        else $error("return not two cycles");
    a_sleep_entry: assert property (is_slp |=> sleeping_o && !osc_run_o
        && watchdog_counter_o == 8'h00 && status_o[1:0] == 2'h2
        && status_o[3:2] == $past(status_o[3:2])) else $error("sleep entry wrong");
    a_flush_ignore: assert property (discard_o |=> $stable(w_o) && !sleeping_o)
        else $error("discarded word had an effect");
endmodule
bind cie_core cie_core_monitor cie_core_monitor_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i), .wake_i(wake_i), .call_i(call_i),
    .program_counter_o(program_counter_o), .w_o(w_o), .status_o(status_o),
    .watchdog_counter_o(watchdog_counter_o), .sleeping_o(sleeping_o),
    .osc_run_o(osc_run_o), .discard_o(discard_o));
`default_nettype wire

// file: verification/tb_core_instr_exec_subset.sv
// Self-checking bench for the execution core against an integer model.
// Assumes file registers start unknown, so they are cleared first.
`timescale 1ns/100ps
`default_nettype none
module tb_core_instr_exec_subset;
    logic                 core_clk, rst, valid, wake, call;
    logic [13:0]          instr;
    logic [12:0]          pc;
    logic [7:0]           w, wdt;
    cie_pkg::cie_status_s st;
    logic                 slp, osc, disc;
    logic [31:0]          seed = 32'h000113A1;
    int                   fm[128];
    int                   mw, mc, mz, err_count, comparisons, p, q;

    cie_core cie_core_inst (.core_clk_i(core_clk), .rst_i(rst), .instr_i(instr),
        .instr_valid_i(valid), .wake_i(wake), .call_i(call), .program_counter_o(pc),
        .w_o(w), .status_o(st), .watchdog_counter_o(wdt), .sleeping_o(slp),
        .osc_run_o(osc), .discard_o(disc));

    // Free-running 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Present one word for one edge, valid stays up
    task automatic issue(logic [13:0] word, logic c);
        instr = word;
        call  = c;
        valid = 1'b1;
        @(posedge core_clk);
        #1;
    endtask

    task automatic idle(int n);
        valid = 1'b0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset();
        valid = 1'b0;
        rst   = 1'b1;
        repeat (16) @(posedge core_clk);
        #1 rst = 1'b0;
        {mw, mc, mz} = '0;
        chk("reset state", 16'h001A, {st, slp, osc, disc});
    endtask

    // Model one byte operation, execute it, compare
    task automatic run(logic [13:0] word);
        int a, b, r;
        a = word[6:0];
        b = fm[a];
        r = -1;
        if (word[13:8] == cie_pkg::OP_AND_WF) begin
            r = mw & b;
            mz = (r == 0);
        end else if (word[13:8] == cie_pkg::OP_RLC) begin
            r = ((b << 1) | mc) & 255;
            mc = b >> 7;
        end else if (word[13:8] == cie_pkg::OP_RRC) begin
            r = (b >> 1) | (mc << 7);
            mc = b & 1;
        end
        if (r >= 0 && word[7]) fm[a] = r;
        else if (r >= 0) mw = r;
        issue(word, 1'b0);
        chk("w", mw[15:0], {8'h00, w});
        chk("carry zero", {mc[7:0], mz[7:0]}, {7'h00, st.carry, 7'h00, st.zero});
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        print_verdict();
    end

    initial begin
        {rst, valid, wake, call, instr} = '0;
        for (int i = 0; i < 128; i++) fm[i] = 0;
        do_reset();
        for (int a = 0; a < 128; a++) run({cie_pkg::OP_AND_WF, 1'b1, a[6:0]});
        do_reset();
        $display("test clear done");
        for (int i = 0; i < 32; i++) begin
            p = xs();
            if (p[1:0] == 2'h0) run({cie_pkg::OP_AND_WF, p[8], p[15:9]});
            else if (p[0]) run({cie_pkg::OP_RLC, p[8], p[15:9]});
            else run({cie_pkg::OP_RRC, p[8], p[15:9]});
        end
        $display("test byte ops done");
        for (int b = 0; b < 8; b++) begin
            p = xs();
            issue({cie_pkg::OP_BTSC, b[2:0], p[6:0]}, 1'b0);
            chk("skip flag", {15'h0000, fm[p[6:0]][b] == 0}, {15'h0000, disc});
            chk("flags kept", {mc[0], mz[0], 2'h3}, st);
            issue(cie_pkg::OP_SLEEP, 1'b0);
            chk("flushed word", 16'h0000, {14'h0000, slp, disc});
        end
        $display("test bit skip done");
        p = pc;
        issue(cie_pkg::OP_NOP, 1'b1);
        q = pc;
        issue(cie_pkg::OP_NOP, 1'b1);
        issue(cie_pkg::OP_RET, 1'b0);
        chk("inner return", q[15:0] + 16'h2001, {2'h0, disc, pc});
        idle(1);
        issue(cie_pkg::OP_RET, 1'b0);
        chk("outer return", p[15:0] + 16'h2001, {2'h0, disc, pc});
        chk("return flags", {mc[0], mz[0], 2'h3}, st);
        $display("test return done");
        idle(600);
        issue(cie_pkg::OP_SLEEP, 1'b0);
        chk("sleep entry", 16'h002A, {wdt, st[1:0], slp, osc, 2'h2});
        issue({cie_pkg::OP_RLC, 1'b0, 7'h05}, 1'b0);
        idle(20);
        chk("asleep", 16'h0029, {wdt, st[1:0], slp, osc, 2'h1});
        wake = 1'b1;
        for (int k = 0; k < 8 && slp !== 1'b0; k++) @(posedge core_clk) #1;
        wake = 1'b0;
        chk("awake", 16'h0001, {14'h0000, slp, osc});
        $display("test sleep done");
        print_verdict();
    end
endmodule
`default_nettype wire
